// file: hw/dmp_pkg.sv
// constants for the dual-modulus divide-by-10/11 prescaler
package dmp_pkg;
  localparam int unsigned DMP_RATIO_LOW    = 10;
  localparam int unsigned DMP_RATIO_HIGH   = 11;
  localparam int unsigned DMP_COUNT_WIDTH  = 4;
  localparam int unsigned DMP_HIGH_COUNTS  = 5;
  localparam logic [3:0]  DMP_COUNT_RESET  = 4'h0;
  localparam logic        DMP_OUT_RESET    = 1'b0;
  localparam logic [1:0]  DMP_EDGE_RESET   = 2'h0;
endpackage

// file: hw/dmp_clock_gate.sv
// rising-edge detector for one clock input, held off by the other input
module dmp_clock_gate (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  // pins
  input  wire logic i_clock_pin,
  input  wire logic i_inhibit_pin,
  // event
  output logic      o_count_edge
);
  import dmp_pkg::*;

  typedef struct packed {
    logic last;
  } dmp_gate_s;

  dmp_gate_s state;
  dmp_gate_s next_state;

  always_comb begin
    next_state      = state;
    next_state.last = i_clock_pin;
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // inhibit high blocks the edge entirely
  assign o_count_edge = i_clock_pin && !state.last && !i_inhibit_pin; // R04 R08
endmodule

// file: hw/dmp_prescaler.sv
// dual-modulus divide-by-10/11 prescaler core
// What this block does
// (R01) either modulus select high: divide by ten
// (R02) both selects low: divide by eleven
// (R03) both clock inputs are interchangeable
// (R04) unused clock input high inhibits counting
// (R05) unconnected inputs read as low, through pull-downs outside this block
// (R06) ten takes effect at later rising edge
// (R07) eleven takes effect at later rising edge
// (R08) one output period per division cycle
module dmp_prescaler #(
  // ratio pair and length of the high half of the output
  parameter int unsigned RATIO_LOW   = dmp_pkg::DMP_RATIO_LOW,
  parameter int unsigned RATIO_HIGH  = dmp_pkg::DMP_RATIO_HIGH,
  parameter int unsigned HIGH_COUNTS = dmp_pkg::DMP_HIGH_COUNTS
) (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  // clock inputs, either one may carry the clock
  input  wire logic i_clock_in_a,
  input  wire logic i_clock_in_b,
  // modulus control
  input  wire logic i_modulus_select_a,
  input  wire logic i_modulus_select_b,
  // divided output
  output logic      o_divided,
  output logic      o_cycle_end,
  output logic      o_ratio_ten
);
  import dmp_pkg::*;

  // refuse settings the counter cannot serve
  if (RATIO_LOW < 2) begin : g_low_too_small
    $error("low ratio must be at least two");
  end
  if (RATIO_HIGH != RATIO_LOW + 1) begin : g_pair_not_adjacent
    $error("high ratio must be one above the low ratio");
  end
  if (RATIO_HIGH > (1 << DMP_COUNT_WIDTH)) begin : g_count_too_narrow
    $error("count too narrow for the high ratio");
  end
  if (HIGH_COUNTS == 0 || HIGH_COUNTS >= RATIO_LOW) begin : g_duty_out_of_range
    $error("high half must be shorter than a cycle");
  end
  // the check counter below is five bits wide
  if (RATIO_HIGH > 32) begin : g_check_counter_narrow
    $error("cycle counter for checks too narrow");
  end

  typedef struct packed {
    logic [DMP_COUNT_WIDTH-1:0] count;
    logic                       out;
    logic                       ten;
  } dmp_core_s;

  dmp_core_s state;
  dmp_core_s next_state;
  logic      edge_a;
  logic      edge_b;
  logic      count_edge;
  logic      select_ten;
  logic [DMP_COUNT_WIDTH-1:0] last_count;

  // each input gated by the other, so the pair is symmetric
  dmp_clock_gate u_gate_a ( // R03
    .i_clock       (i_clock),
    .i_reset_n     (i_reset_n),
    .i_clock_pin   (i_clock_in_a),
    .i_inhibit_pin (i_clock_in_b),
    .o_count_edge  (edge_a)
  );

  dmp_clock_gate u_gate_b ( // R03
    .i_clock       (i_clock),
    .i_reset_n     (i_reset_n),
    .i_clock_pin   (i_clock_in_b),
    .i_inhibit_pin (i_clock_in_a),
    .o_count_edge  (edge_b)
  );

  // pull-downs live outside; a floating pin arrives here as 0
  assign count_edge = edge_a || edge_b; // R05
  assign select_ten = i_modulus_select_a || i_modulus_select_b; // R01 R02

  // ratio sampled on the clock edge itself, so a change needs a later edge
  assign last_count = select_ten ? DMP_COUNT_WIDTH'(RATIO_LOW - 1)
                                 : DMP_COUNT_WIDTH'(RATIO_HIGH - 1); // R06 R07

  always_comb begin
    next_state = state;
    if (count_edge) begin
      next_state.ten = select_ten;
      if (state.count >= last_count) begin
        next_state.count = DMP_COUNT_RESET; // R08
      end else begin
        next_state.count = state.count + DMP_COUNT_WIDTH'(1);
      end
      // high for the first HIGH_COUNTS counts of the cycle
      next_state.out = (next_state.count < DMP_COUNT_WIDTH'(HIGH_COUNTS));
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state.count <= DMP_COUNT_RESET;
      state.out   <= DMP_OUT_RESET;
      state.ten   <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign o_divided   = state.out;
  assign o_ratio_ten = state.ten;
  assign o_cycle_end = count_edge && (state.count >= last_count);

  // cycle counter for checks
  logic [4:0] edges_in_cycle;
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      edges_in_cycle <= 5'h0;
    end else if (count_edge) begin
      edges_in_cycle <= o_cycle_end ? 5'h0 : edges_in_cycle + 5'h1;
    end
  end

  // steps of a division cycle
  sequence s_closing_edge;
    count_edge && (state.count >= last_count);
  endsequence
  sequence s_fresh_cycle;
    (state.count == DMP_COUNT_RESET) && state.out;
  endsequence
  sequence s_ten_last;
    count_edge && select_ten && (state.count == DMP_COUNT_WIDTH'(RATIO_LOW - 1));
  endsequence
  sequence s_eleven_step;
    count_edge && !select_ten && (state.count == DMP_COUNT_WIDTH'(RATIO_LOW - 1));
  endsequence
  sequence s_eleven_last;
    count_edge && !select_ten && (state.count == DMP_COUNT_WIDTH'(RATIO_HIGH - 1));
  endsequence

  // ratio and wrap points
  ten_wraps_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R01 R06
    s_ten_last
    |=> s_fresh_cycle)
    else $error("ten ratio did not wrap at nine");
  eleven_wraps_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R02 R07
    s_eleven_step
    |=> state.count == DMP_COUNT_WIDTH'(RATIO_HIGH - 1))
    else $error("eleven ratio wrapped early");
  eleven_last_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R02
    s_eleven_last
    |=> s_fresh_cycle)
    else $error("eleven ratio did not wrap at ten");
  end_restarts_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R08
    s_closing_edge
    |=> s_fresh_cycle)
    else $error("cycle end did not restart the count");
  end_late_enough_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R01 R02
    o_cycle_end
    |-> state.count >= DMP_COUNT_WIDTH'(RATIO_LOW - 1))
    else $error("cycle ended before the low ratio");

  // inhibit and idle pins
  inhibit_holds_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R04
    (i_clock_in_a && i_clock_in_b) |=> $stable(state.count))
    else $error("count moved while inhibited");
  inhibit_a_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R04
    i_clock_in_b
    |-> !edge_a)
    else $error("input a counted while b high");
  inhibit_b_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R03 R04
    i_clock_in_a
    |-> !edge_b)
    else $error("input b counted while a high");
  no_edge_still_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R04 R05
    !count_edge
    |=> $stable(state.count) && $stable(o_divided))
    else $error("state moved without a counting edge");

  // output shape
  cycle_len_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R08
    o_cycle_end |-> edges_in_cycle == 5'(RATIO_LOW - 1) || edges_in_cycle == 5'(RATIO_HIGH - 1))
    else $error("division cycle length wrong");
  count_range_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R08
    state.count <= DMP_COUNT_WIDTH'(RATIO_HIGH - 1))
    else $error("count out of range");
  duty_split_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R08
    count_edge
    |=> o_divided == (state.count < DMP_COUNT_WIDTH'(HIGH_COUNTS)))
    else $error("output level wrong for count");
  end_pulse_single_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R08
    o_cycle_end
    |=> !o_cycle_end)
    else $error("cycle end stood two cycles");
  reset_clears_a: assert property (@(posedge i_clock) // R08
    !i_reset_n
    |=> state.count == DMP_COUNT_RESET && !o_divided && !o_ratio_ten)
    else $error("reset did not clear the count");
  ratio_kept_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R06 R07
    !count_edge
    |=> $stable(o_ratio_ten))
    else $error("ratio flag moved without an edge");
  idle_still_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R05
    (!i_clock_in_a && !i_clock_in_b) |=> $stable(state.count))
    else $error("count moved with both clock inputs low");
  symmetric_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R03
    (edge_a || edge_b) && !(state.count >= last_count) |=> state.count == $past(state.count) + 4'h1)
    else $error("edge on either input did not count");
  ratio_flag_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R06 R07
    count_edge |=> o_ratio_ten == $past(select_ten))
    else $error("ratio flag not taken at edge");
endmodule

// file: tb/dmp_ctrl_model.sv
// modulus-control model standing in for the synthesiser counter
module dmp_ctrl_model (
  // clock
  input  wire logic       i_clock,
  // requested selects from the bench
  input  wire logic [1:0] i_mode,
  // modulus selects toward the prescaler
  output logic            o_sel_a,
  output logic            o_sel_b
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_sel_a = 1'b0;
    o_sel_b = 1'b0;
  end
  // change just after an edge, so selects are settled before the next pin edge
  always @(posedge i_clock) begin
    o_sel_a <= i_mode[0];
    o_sel_b <= i_mode[1];
  end
endmodule

// file: tb/dmp_prescaler_tb.sv
// self-checking bench for the divide-by-10/11 prescaler
module dmp_prescaler_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dmp_pkg::*;
  logic       i_clock = 1'b0;
  logic       i_reset_n = 1'b0;
  logic       pin_a = 1'b0;
  logic       pin_b = 1'b0;
  logic [1:0] mode = 2'h0;
  logic       sel_a, sel_b, divided, cycle_end, ratio_ten, ended, high;
  int         n_mismatch = 0;
  int         n_compared = 0;
  int         cycles = 0;
  initial forever #20 i_clock = ~i_clock;
  dmp_ctrl_model ctrl_u (.i_clock(i_clock), .i_mode(mode), .o_sel_a(sel_a), .o_sel_b(sel_b));
  dmp_prescaler dut_u (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_clock_in_a(pin_a),
    .i_clock_in_b(pin_b), .i_modulus_select_a(sel_a), .i_modulus_select_b(sel_b),
    .o_divided(divided), .o_cycle_end(cycle_end), .o_ratio_ten(ratio_ten));
  task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // one cycle high, one low: the tightest spacing accepted
  task automatic pulse(input bit use_b);
    @(posedge i_clock);
    if (use_b) pin_b <= 1'b1; else pin_a <= 1'b1;
    #5;
    ended = cycle_end;
    high = divided;
    @(posedge i_clock);
    if (use_b) pin_b <= 1'b0; else pin_a <= 1'b0;
  endtask
  // first cycle after a select change is only for alignment
  task automatic measure(logic [1:0] m, bit use_b, int exp);
    int n = 0;
    int h = 0;
    mode <= m;
    repeat (12) begin pulse(use_b); if (ended === 1'b1) break; end
    repeat (12) begin pulse(use_b); n++; h += (high === 1'b1); if (ended === 1'b1) break; end
    // let the closing edge settle before the flag is read
    #5;
    check("cycle length", n[3:0], exp[3:0]);
    check("high counts", h[3:0], 4'h5);
    check("ratio flag", {3'h0, ratio_ten}, {3'h0, exp == DMP_RATIO_LOW});
  endtask
  task automatic test_ratios;
    measure(2'h0, 1'b0, DMP_RATIO_HIGH);
    for (int m = 1; m < 4; m++) measure(m[1:0], 1'b0, DMP_RATIO_LOW);
    measure(2'h0, 1'b0, DMP_RATIO_HIGH);
  endtask
  task automatic test_swap;
    measure(2'h0, 1'b1, DMP_RATIO_HIGH);
    measure(2'h2, 1'b1, DMP_RATIO_LOW);
  endtask
  task automatic test_inhibit;
    int e = 0;
    pin_b <= 1'b1;
    repeat (24) begin pulse(1'b0); e += (ended === 1'b1); end
    check("inhibited ends", e[3:0], 4'h0);
    pin_b <= 1'b0;
  endtask
  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // a stuck test would otherwise run forever; stop after 5000 clock cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge i_clock);
    i_reset_n <= 1'b1;
    #5;
    check("reset out", {3'h0, divided}, {3'h0, DMP_OUT_RESET});
    test_ratios();
    test_swap();
    test_inhibit();
    summarize();
  end
endmodule
